/* hw/eni_regs.vh */
// Register map, field positions and timing counts of the integrator.
`ifndef ENI_REGS_VH
`define ENI_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ENI_CTRL 9'h000
`define ENI_STATUS 9'h004
`define ENI_PRESET 9'h008
`define ENI_RT_START 9'h00c
`define ENI_RT_END 9'h010
`define ENI_LIMIT 9'h014
`define ENI_ELAPSED 9'h018
`define ENI_IRQ_STAT 9'h01c
`define ENI_IRQ_MASK 9'h020
`define ENI_UNIT_MAP 9'h024
`define ENI_MEM_BIT 8
`define ENI_ACC_WORDS 6'h30
`define ENI_ACC_LAST 6'h2f

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTRL_MODE_MSB 2
`define CTRL_START 4
`define CTRL_STOP 5
`define CTRL_RESET 6
`define MODE_MANUAL 3'h0
`define MODE_NORMAL 3'h1
`define MODE_REPEAT 3'h2
`define MODE_RT 3'h3
`define MODE_RT_REP 3'h4
`define IRQ_STOP 0
`define IRQ_LIMIT 1
`define IRQ_TMAX 2
`define IRQ_OVR 3
`define IRQ_RESTART 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PRESET_RST 32'h0000_0e10
`define LIMIT_RST 32'h3b9a_c9ff
`define MASK_RST 5'h00
`define UNIT_MAP_RST 4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define TICK_NS 1000000000
`define TIME_MAX_H 10000
`define SEC_PER_H 3600

`endif

/* hw/eni_acc_mem.v */
// Accumulator memory with one write port and two registered read ports.
`timescale 1ns/10ps
`include "eni_regs.vh"
module eni_acc_mem
(
  input wire clk,
  input wire arst_n,
  input wire we,
  input wire [5:0] waddr,
  input wire [31:0] wdata,
  input wire [5:0] raddr_a,
  output reg [31:0] rdata_a,
  input wire [5:0] raddr_b,
  input wire ext_sel,
  input wire [31:0] ext_data,
  output reg [31:0] rdata_b
);

reg [31:0] mem [0:47];

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
always @(posedge clk)
begin
  if (we)
    mem[waddr] <= wdata;
end

// Port b also carries register words so the bus sees one flop.
always @(posedge clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    rdata_a <= 32'h0000_0000;
    rdata_b <= 32'h0000_0000;
  end
  else
  begin
    rdata_a <= mem[raddr_a];
    rdata_b <= ext_sel ? ext_data : mem[raddr_b];
  end
end

endmodule

/* hw/eni_integrator.v */
// Energy and charge integrator with five run modes and a register port.
`timescale 1ns/10ps
`include "eni_regs.vh"
module eni_integrator
#(
  parameter [31:0] TICK_CYC = `TICK_NS / `CLK_PERIOD_NS,
  parameter [31:0] TIME_MAX_S = `TIME_MAX_H * `SEC_PER_H
)
(
  input wire core_clk,
  input wire arst_n,
  input wire [8:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output wire [31:0] bus_rdata,
  input wire [31:0] rtc_now,
  input wire smp_valid,
  input wire [1:0] smp_elem,
  input wire [15:0] smp_p,
  input wire [15:0] smp_i,
  input wire [15:0] smp_s,
  input wire [15:0] smp_q,
  output reg irq,
  output reg integ_run
);

localparam C_IDLE = 2'd0;
localparam C_ARM = 2'd1;
localparam C_RUN = 2'd2;
localparam C_HOLD = 2'd3;
localparam E_CLR = 2'd0;
localparam E_IDLE = 2'd1;
localparam E_RD = 2'd2;
localparam E_WR = 2'd3;

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
function is_rt;
  input [2:0] m;
  begin
    is_rt = (m == `MODE_RT) || (m == `MODE_RT_REP);
  end
endfunction

function [31:0] sext;
  input [15:0] v;
  begin
    sext = {{16{v[15]}}, v};
  end
endfunction

// Contribution of one sample to accumulator k of a group.
function [31:0] contrib;
  input [2:0] k;
  input [15:0] p;
  input [15:0] i;
  input [15:0] s;
  input [15:0] q;
  begin
    case (k)
    3'd0: contrib = sext(p);
    3'd1: contrib = p[15] ? 32'h0000_0000 : sext(p);
    3'd2: contrib = p[15] ? sext(p) : 32'h0000_0000;
    3'd3: contrib = sext(i);
    3'd4: contrib = i[15] ? 32'h0000_0000 : sext(i);
    3'd5: contrib = i[15] ? sext(i) : 32'h0000_0000;
    3'd6: contrib = sext(s);
    default: contrib = sext(q);
    endcase
  end
endfunction

function over_lim;
  input [31:0] v;
  input [31:0] lim;
  begin
    over_lim = ($signed(v) >= $signed(lim)) ||
      ($signed(v) <= $signed(32'h0000_0000 - lim));
  end
endfunction

// ----------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------
reg [1:0] ctl, next_ctl;
reg [2:0] mode;
reg [31:0] preset, rt_start, rt_end, limit;
reg [31:0] elapsed, pre_cnt;
reg [4:0] irq_stat, irq_mask, next_irq_stat;
reg [3:0] unit_map;
reg [4:0] ev;
reg restart, clr_pend, lim_hit;
reg [1:0] eng, lat_elem;
reg [5:0] step;
reg [15:0] lat_p, lat_i, lat_s, lat_q;
reg [31:0] reg_val;
wire [31:0] acc_old;
wire [2:0] k = step[2:0];
wire [5:0] acc_idx;
wire [31:0] acc_new;
wire wr_ctrl = bus_wr && (bus_addr == `ENI_CTRL);
wire cmd_start = wr_ctrl && bus_wdata[`CTRL_START];
wire cmd_stop = wr_ctrl && bus_wdata[`CTRL_STOP];
wire cmd_reset = wr_ctrl && bus_wdata[`CTRL_RESET];
wire rd_stat = bus_rd && (bus_addr == `ENI_IRQ_STAT);
wire mem_hit = bus_addr[`ENI_MEM_BIT] &&
  (bus_addr[7:2] < `ENI_ACC_WORDS);
wire smp_take = smp_valid && (ctl == C_RUN) && (eng == E_IDLE) &&
  !clr_pend && !restart && (next_ctl == C_RUN);

// Units sit above the elements: index is group then quantity.
assign acc_idx = step[3] ? {2'b10, unit_map[lat_elem], k} :
  {1'b0, lat_elem, k};
assign acc_new = acc_old + contrib(k, lat_p, lat_i, lat_s, lat_q);

// ----------------------------------------------------------------
// Run control
// ----------------------------------------------------------------
always @*
begin
  next_ctl = ctl;
  ev = 5'h00;
  restart = 1'b0;
  case (ctl)
  C_IDLE:
    if (cmd_start)
      next_ctl = is_rt(mode) ? C_ARM : C_RUN;
  C_ARM:
    if (cmd_stop || rtc_now >= rt_end)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_STOP] = 1'b1;
    end
    else if (rtc_now >= rt_start)
      next_ctl = C_RUN;
  C_RUN:
    if (lim_hit)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_LIMIT] = 1'b1;
    end
    else if (elapsed >= TIME_MAX_S)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_TMAX] = 1'b1;
    end
    else if (cmd_stop)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_STOP] = 1'b1;
    end
    else if (is_rt(mode) && rtc_now >= rt_end)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_STOP] = 1'b1;
    end
    else if (mode == `MODE_NORMAL && elapsed >= preset)
    begin
      next_ctl = C_HOLD;
      ev[`IRQ_STOP] = 1'b1;
    end
    else if ((mode == `MODE_REPEAT || mode == `MODE_RT_REP) &&
      elapsed >= preset && !clr_pend)
    begin
      restart = 1'b1;
      ev[`IRQ_RESTART] = 1'b1;
    end
  C_HOLD:
    next_ctl = C_HOLD;
  default:
    next_ctl = C_IDLE;
  endcase
  if (smp_valid && ctl == C_RUN && !smp_take)
    ev[`IRQ_OVR] = 1'b1;
  if (cmd_reset)
    next_ctl = C_IDLE;
end

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    ctl <= C_IDLE;
    integ_run <= 1'b0;
    mode <= `MODE_MANUAL;
  end
  else
  begin
    ctl <= next_ctl;
    integ_run <= (next_ctl == C_RUN);
    if (wr_ctrl && ctl == C_IDLE &&
      bus_wdata[`CTRL_MODE_MSB:0] <= `MODE_RT_REP)
      mode <= bus_wdata[`CTRL_MODE_MSB:0];
  end
end

// ----------------------------------------------------------------
// Integration time
// ----------------------------------------------------------------
// Time only advances while running, so a hold freezes it as well.
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    pre_cnt <= 32'h0000_0000;
    elapsed <= 32'h0000_0000;
  end
  else if (cmd_reset || restart)
  begin
    pre_cnt <= 32'h0000_0000;
    elapsed <= 32'h0000_0000;
  end
  else if (ctl == C_RUN && next_ctl == C_RUN)
  begin
    if (pre_cnt == TICK_CYC - 32'h0000_0001)
    begin
      pre_cnt <= 32'h0000_0000;
      elapsed <= elapsed + 32'h0000_0001;
    end
    else
      pre_cnt <= pre_cnt + 32'h0000_0001;
  end
end

// ----------------------------------------------------------------
// Accumulation engine
// ----------------------------------------------------------------
// Memory is not reset, so the engine wipes it after every reset.
always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    eng <= E_CLR;
    step <= 6'h00;
    clr_pend <= 1'b0;
    lim_hit <= 1'b0;
    lat_elem <= 2'h0;
    lat_p <= 16'h0000;
    lat_i <= 16'h0000;
    lat_s <= 16'h0000;
    lat_q <= 16'h0000;
  end
  else
  begin
    lim_hit <= 1'b0;
    if (cmd_reset || restart)
      clr_pend <= 1'b1;
    case (eng)
    E_CLR:
      if (step == `ENI_ACC_LAST)
      begin
        eng <= E_IDLE;
        step <= 6'h00;
      end
      else
        step <= step + 6'h01;
    E_IDLE:
      if (clr_pend)
      begin
        eng <= E_CLR;
        step <= 6'h00;
        clr_pend <= cmd_reset || restart;
      end
      else if (smp_take)
      begin
        eng <= E_RD;
        step <= 6'h00;
        lat_elem <= smp_elem;
        lat_p <= smp_p;
        lat_i <= smp_i;
        lat_s <= smp_s;
        lat_q <= smp_q;
      end
    E_RD:
      eng <= E_WR;
    E_WR:
    begin
      if (over_lim(acc_new, limit))
        lim_hit <= 1'b1;
      if (step == 6'h0f)
        eng <= E_IDLE;
      else
        eng <= E_RD;
      step <= step + 6'h01;
    end
    default:
      eng <= E_CLR;
    endcase
  end
end

eni_acc_mem u_mem
(
  .clk(core_clk),
  .arst_n(arst_n),
  .we((eng == E_CLR) || (eng == E_WR)),
  .waddr((eng == E_CLR) ? step : acc_idx),
  .wdata((eng == E_CLR) ? 32'h0000_0000 : acc_new),
  .raddr_a(acc_idx),
  .rdata_a(acc_old),
  .raddr_b(bus_addr[7:2]),
  .ext_sel(!(bus_rd && mem_hit)),
  .ext_data(bus_rd ? reg_val : 32'h0000_0000),
  .rdata_b(bus_rdata)
);

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
always @*
begin
  case (bus_addr)
  `ENI_CTRL: reg_val = {29'h0, mode};
  `ENI_STATUS: reg_val = {29'h0, ctl == C_HOLD, ctl == C_ARM,
    ctl == C_RUN};
  `ENI_PRESET: reg_val = preset;
  `ENI_RT_START: reg_val = rt_start;
  `ENI_RT_END: reg_val = rt_end;
  `ENI_LIMIT: reg_val = limit;
  `ENI_ELAPSED: reg_val = elapsed;
  `ENI_IRQ_STAT: reg_val = {27'h0, irq_stat};
  `ENI_IRQ_MASK: reg_val = {27'h0, irq_mask};
  `ENI_UNIT_MAP: reg_val = {28'h0, unit_map};
  default: reg_val = 32'h0000_0000;
  endcase
end

always @*
begin
  // A new event beats the clear by read in the same cycle.
  next_irq_stat = (rd_stat ? 5'h00 : irq_stat) | ev;
end

always @(posedge core_clk or negedge arst_n)
begin
  if (!arst_n)
  begin
    preset <= `PRESET_RST;
    rt_start <= 32'h0000_0000;
    rt_end <= 32'h0000_0000;
    limit <= `LIMIT_RST;
    irq_mask <= `MASK_RST;
    unit_map <= `UNIT_MAP_RST;
    irq_stat <= 5'h00;
    irq <= 1'b0;
  end
  else
  begin
    irq_stat <= next_irq_stat;
    irq <= |(next_irq_stat & irq_mask);
    if (bus_wr)
    begin
      case (bus_addr)
      `ENI_PRESET: preset <= bus_wdata;
      `ENI_RT_START: rt_start <= bus_wdata;
      `ENI_RT_END: rt_end <= bus_wdata;
      `ENI_LIMIT: limit <= bus_wdata;
      `ENI_IRQ_MASK: irq_mask <= bus_wdata[4:0];
      `ENI_UNIT_MAP: unit_map <= bus_wdata[3:0];
      default: ;
      endcase
    end
  end
end

endmodule

/* tb/eni_ctl_model.sv */
// Instrument-side model: calendar clock and sample source.
`timescale 1ns/10ps
module eni_ctl_model
#(
  parameter int TICK = 10
)
(
  input wire core_clk,
  input wire arst_n,
  input wire send,
  input wire [1:0] elem,
  input wire [63:0] val,
  output logic [31:0] rtc_now,
  output logic smp_valid,
  output logic [1:0] smp_elem,
  output logic [63:0] smp_val
);
  int tk;
  // Idle sample fields toggle every cycle between the inverse of the last value and the value itself, so a design
  // that reads them outside the strobe cannot pass by luck.
  always @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      rtc_now <= 32'h0000_1000;
      tk <= 0;
      smp_valid <= 1'b0;
      smp_elem <= 2'h0;
      smp_val <= 64'h0;
    end
    else
    begin
      tk <= (tk == TICK - 1) ? 0 : tk + 1;
      if (tk == TICK - 1)
        rtc_now <= rtc_now + 32'h1;
      smp_valid <= send;
      smp_elem <= send ? elem : ~smp_elem;
      smp_val <= send ? val : ~smp_val;
    end
endmodule

/* tb/eni_integrator_sva.sv */
// Port checker of the integrator.
`timescale 1ns/10ps
`include "eni_regs.vh"
module eni_integrator_sva
#(
  parameter [31:0] TICK_CYC = 10,
  parameter [31:0] TIME_MAX_S = 20
)
(
  input wire core_clk,
  input wire arst_n,
  input wire [8:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire [31:0] rtc_now,
  input wire smp_valid,
  input wire [1:0] smp_elem,
  input wire [15:0] smp_p,
  input wire [15:0] smp_i,
  input wire [15:0] smp_s,
  input wire [15:0] smp_q,
  input wire irq,
  input wire integ_run
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire ctl_wr = bus_wr && bus_addr == `ENI_CTRL;
  wire st_rd = bus_rd && bus_addr == `ENI_STATUS;
  wire hole = (bus_addr >= 9'h028 && bus_addr < 9'h100) || bus_addr >= 9'h1c0;
  a_rdata_quiet: assert property (!bus_rd
    |=> bus_rdata == 32'h0) else $error("read data outside answer cycle");
  a_hole_zero: assert property (bus_rd && hole
    |=> bus_rdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_pulse: assert property (bus_rd && bus_addr == `ENI_CTRL
    |=> bus_rdata[6:4] == 3'h0) else $error("command bits read back");
  a_status_run: assert property (st_rd
    |=> bus_rdata[0] == $past(integ_run)) else $error("running bit wrong");
  a_state_one: assert property (st_rd
    |=> $onehot0(bus_rdata[2:0])) else $error("state bits overlap");
  a_stop_halts: assert property (ctl_wr && bus_wdata[5] && integ_run
    |=> !integ_run) else $error("stop ignored");
  a_soft_idle: assert property (ctl_wr && bus_wdata[6]
    |=> !integ_run) else $error("soft reset left run");
  a_reset_clean: assert property ($rose(arst_n)
    |-> bus_rdata == 32'h0 && !irq && !integ_run) else $error("reset dirty");
  c_stop: cover property (ctl_wr && bus_wdata[5] && integ_run);
  c_sample: cover property (smp_valid && integ_run);
  c_irq: cover property ($rose(irq));
endmodule
bind eni_integrator eni_integrator_sva #(.TICK_CYC(TICK_CYC),
  .TIME_MAX_S(TIME_MAX_S)) u_sva (.core_clk(core_clk), .arst_n(arst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rtc_now(rtc_now),
  .smp_valid(smp_valid), .smp_elem(smp_elem), .smp_p(smp_p),
  .smp_i(smp_i), .smp_s(smp_s), .smp_q(smp_q), .irq(irq),
  .integ_run(integ_run));

/* tb/energy_integrator_modes_bench.sv */
// Self-checking bench of the energy integrator.
`timescale 1ns/10ps
`include "eni_regs.vh"
module energy_integrator_modes_bench;
  logic core_clk, arst_n, bus_wr, bus_rd, send, irq, integ_run, smp_valid;
  logic [8:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, rtc_now, d;
  logic [1:0] elem, smp_elem;
  logic [63:0] val, smp_val;
  int n_mismatch, checked, cyc;
  int ea[8] = '{5, 5, 0, -3, 0, -3, 7, -2};
  int eb[8] = '{-4, 0, -4, 2, 2, 0, 3, 1};
  eni_integrator #(.TICK_CYC(32'd10), .TIME_MAX_S(32'd20)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .rtc_now(rtc_now), .smp_valid(smp_valid),
    .smp_elem(smp_elem), .smp_p(smp_val[63:48]), .smp_i(smp_val[47:32]),
    .smp_s(smp_val[31:16]), .smp_q(smp_val[15:0]), .irq(irq),
    .integ_run(integ_run));
  eni_ctl_model #(.TICK(10)) i_ctl (.core_clk(core_clk), .arst_n(arst_n),
    .send(send), .elem(elem), .val(val), .rtc_now(rtc_now),
    .smp_valid(smp_valid), .smp_elem(smp_elem), .smp_val(smp_val));
  // ----------------------------------------------------------------
  // Bus, sample and compare tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task wr(input [8:0] a, input [31:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input [8:0] a);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge core_clk);
  endtask
  task rchk(input string nm, input [8:0] a, input [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask
  task smp(input [1:0] e, input [63:0] v);
    elem <= e;
    val <= v;
    send <= 1'b1;
    @(posedge core_clk);
    send <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask
  task wait_run(input logic v, input int n);
    for (int k = 0; k < n && integ_run !== v; k++)
      @(posedge core_clk);
    chkb("integ_run", v, integ_run);
  endtask
  // The start decision looks at the stored mode, so set it first.
  task go(input [2:0] m);
    wr(`ENI_CTRL, 32'(m));
    wr(`ENI_CTRL, 32'h10 | 32'(m));
  endtask
  // Soft reset rewipes the memory, so wait it out.
  task sreset;
    wr(`ENI_CTRL, 32'h40);
    repeat (52) @(posedge core_clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    wr(`ENI_ELAPSED, 32'h5);
    rchk("preset", `ENI_PRESET, `PRESET_RST);
    rchk("limit", `ENI_LIMIT, `LIMIT_RST);
    rchk("mask", `ENI_IRQ_MASK, 32'h0);
    rchk("map", `ENI_UNIT_MAP, 32'h0);
    rchk("elapsed", `ENI_ELAPSED, 32'h0);
    rchk("status", `ENI_STATUS, 32'h0);
    rchk("hole", 9'h028, 32'h0);
    rchk("acc", 9'h17c, 32'h0);
  endtask
  task t_acc;
    wr(`ENI_IRQ_MASK, 32'h1f);
    wr(`ENI_UNIT_MAP, 32'h4);
    go(`MODE_MANUAL);
    smp(2'h1, 64'h0005_fffd_0007_fffe);
    smp(2'h2, 64'hfffc_0002_0003_0001);
    for (int k = 0; k < 8; k++)
    begin
      rchk("elem1", 9'h120 + 9'(4 * k), 32'(ea[k]));
      rchk("elem2", 9'h140 + 9'(4 * k), 32'(eb[k]));
      rchk("unit_a", 9'h180 + 9'(4 * k), 32'(ea[k]));
      rchk("unit_b", 9'h1a0 + 9'(4 * k), 32'(eb[k]));
    end
    wr(`ENI_CTRL, 32'h20);
    chkb("stopped", 1'b0, integ_run);
    @(posedge core_clk);
    chkb("irq_set", 1'b1, irq);
    rd(`ENI_IRQ_STAT);
    chkb("stat_stop", 1'b1, d[0]);
    @(posedge core_clk);
    chkb("irq_clr", 1'b0, irq);
  endtask
  task t_limit;
    sreset;
    wr(`ENI_LIMIT, 32'ha);
    go(`MODE_MANUAL);
    // Two strobes in a row: the second meets a busy engine.
    elem <= 2'h3;
    val <= 64'h000c_0000_0000_0000;
    send <= 1'b1;
    @(posedge core_clk);
    smp(2'h3, 64'h000c_0000_0000_0000);
    chkb("lim_run", 1'b0, integ_run);
    rchk("lim_held", `ENI_STATUS, 32'h4);
    rchk("lim_val", 9'h160, 32'hc);
    rd(`ENI_IRQ_STAT);
    chkb("stat_lim", 1'b1, d[1]);
    chkb("stat_ovr", 1'b1, d[3]);
    wr(`ENI_LIMIT, `LIMIT_RST);
  endtask
  task t_tmax;
    sreset;
    go(`MODE_MANUAL);
    wait_run(1'b0, 300);
    rchk("tmax", `ENI_ELAPSED, 32'd20);
    rd(`ENI_IRQ_STAT);
    chkb("stat_tmax", 1'b1, d[2]);
  endtask
  task t_normal;
    sreset;
    wr(`ENI_PRESET, 32'h3);
    go(`MODE_NORMAL);
    wait_run(1'b0, 100);
    rchk("norm_time", `ENI_ELAPSED, 32'h3);
    rchk("norm_held", `ENI_STATUS, 32'h4);
    rd(`ENI_IRQ_STAT);
    chkb("stat_norm", 1'b1, d[0]);
  endtask
  task t_repeat;
    sreset;
    wr(`ENI_PRESET, 32'h6);
    go(`MODE_REPEAT);
    smp(2'h0, 64'h0005_0000_0000_0000);
    repeat (80) @(posedge core_clk);
    rchk("rep_clear", 9'h100, 32'h0);
    chkb("rep_run", 1'b1, integ_run);
    rd(`ENI_IRQ_STAT);
    chkb("stat_rep", 1'b1, d[4]);
    wr(`ENI_CTRL, 32'h20);
    chkb("rep_stop", 1'b0, integ_run);
  endtask
  task t_rt(input [2:0] m);
    sreset;
    wr(`ENI_PRESET, 32'h2);
    wr(`ENI_RT_START, rtc_now + 32'h3);
    wr(`ENI_RT_END, rtc_now + 32'h9);
    rd(`ENI_IRQ_STAT);
    go(m);
    rchk("armed", `ENI_STATUS, 32'h2);
    wait_run(1'b1, 60);
    wait_run(1'b0, 300);
    rchk("rt_held", `ENI_STATUS, 32'h4);
    rd(`ENI_IRQ_STAT);
    chkb("rt_restart", m == `MODE_RT_REP, d[4]);
  endtask
  task report_and_stop;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial
  begin
    {arst_n, bus_wr, bus_rd, send, bus_addr, bus_wdata} = '0;
    elem = 2'h0;
    val = 64'h0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (52) @(posedge core_clk);
    t_regs;
    t_acc;
    t_limit;
    t_tmax;
    t_normal;
    t_repeat;
    t_rt(`MODE_RT);
    t_rt(`MODE_RT_REP);
    report_and_stop;
  end
endmodule
